// ---- inc/srbc_map.vh ----
// Constants for the synchronous receive buffer control block.
// Assumes inclusion by bare name from the design file; definitions only.
// Overview of operation
// - Buffer-select bit reads 0 for primary set, 1 for secondary set.
// - Buffer-select toggles whenever a message transfer ends, good or failed.
// - Receiver idles while done flag of the selected buffer remains set.
// - Writing a buffer's character count register clears that buffer's done flag.
// - Select, match-enable and interrupt-enable are read/write, cleared by reset or init.
// - Match-enable acts only under the general byte protocol.
// - A character match posts a receive interrupt request.
// - Bit 4 of the receive control/status register always reads zero.
// - Receiver-active sets while a message is processed, clears on completion.
// - Receiver-active is read-only, cleared by reset, init or enable negation.
// - Receive enable gates all serial data processing and synchronization search.
`ifndef SRBC_MAP_VH
`define SRBC_MAP_VH
`define SRBC_BIT_ENA      0
`define SRBC_BIT_SEL      2
`define SRBC_BIT_MATCH    3
`define SRBC_BIT_UNUSED4  4
`define SRBC_BIT_IE       5
`define SRBC_BIT_ACT      6
`define SRBC_BIT_DONE_S   7
`define SRBC_BIT_ERR      14
`define SRBC_BIT_DONE_P   15
`define SRBC_CSR_RESET    16'h8080
`define SRBC_MATCH_RESET  8'h00
`define SRBC_FIFO_WIDTH   8
`define SRBC_FIFO_DEPTH   16
`define SRBC_FIFO_AW      4
`endif

// ---- design/srbc_fifo.v ----
// Synchronous FIFO of flip-flops for received characters.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module srbc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_sys_i,
	input  wire             rst_b_i,
	input  wire             clr_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ff;
	reg [AW-1:0]    rd_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            pop;
	localparam [AW:0] FULL_CNT = DEPTH;
	assign in_ready_o  = (cnt_ff != FULL_CNT);
	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign out_data_o  = mem_ff[rd_ff];
	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;
	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
			localparam [AW-1:0] IDX = g;
			always @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i)
					mem_ff[g] <= {WIDTH{1'b0}};
				else if (push && wr_ff == IDX)
					mem_ff[g] <= in_data_i;
			end
		end
	endgenerate
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ff  <= {AW{1'b0}};
			rd_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else if (clr_i) begin
			wr_ff  <= {AW{1'b0}};
			rd_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ff <= wr_ff + 1'b1;
			if (pop)
				rd_ff <= rd_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- design/srbc_top.v ----
// Receive control/status logic: buffer alternation, character match, active flag.
// Assumes characters and message events come from receiver logic on clk_sys_i;
// csr_wr_i/csr_wdata_i/csr_rdata_o form a word-only register port; dma side drains the FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "srbc_map.vh"
module srbc_top (
	input  wire        clk_sys_i,
	input  wire        rst_b_i,
	input  wire        bus_init_i,
	input  wire        csr_wr_i,
	input  wire [15:0] csr_wdata_i,
	output reg  [15:0] csr_rdata_o,
	input  wire        match_wr_i,
	input  wire [7:0]  match_wdata_i,
	input  wire        cnt_pri_wr_i,
	input  wire        cnt_sec_wr_i,
	input  wire        general_byte_protocol_mode_i,
	input  wire        msg_start_i,
	input  wire [7:0]  rx_char_i,
	input  wire        rx_char_valid_i,
	output reg         rx_char_ready_o,
	input  wire        msg_end_i,
	input  wire        msg_error_i,
	output reg  [7:0]  dma_data_o,
	output reg         dma_valid_o,
	input  wire        dma_ready_i,
	output reg         rx_enabled_o,
	output reg         buf_sel_o,
	output reg         irq_o
);
	// ****************************************************************
	// Control and status state
	// ****************************************************************
	reg        ena_ff;
	reg        sel_ff;
	reg        match_en_ff;
	reg        ie_ff;
	reg        act_ff;
	reg        done_p_ff;
	reg        done_s_ff;
	reg        err_ff;
	reg [7:0]  match_ff;
	reg        match_hit_ff;
	wire       clr;
	wire       sel_done;
	wire       run;
	wire       take;
	wire       fifo_in_ready;
	wire [7:0] fifo_out_data;
	wire       fifo_out_valid;
	wire       fifo_pop;
	wire       msg_fin;
	wire       ena_rise;
	reg  [15:0] nxt_rdata;

	assign clr      = bus_init_i;
	assign sel_done = sel_ff ? done_s_ff : done_p_ff;
	assign run      = ena_ff & ~sel_done;
	// Ready is only offered while running with room, so the handshake alone takes a character.
	assign take     = rx_char_valid_i & rx_char_ready_o;
	assign msg_fin  = run & (msg_end_i | msg_error_i);
	assign ena_rise = csr_wr_i & csr_wdata_i[`SRBC_BIT_ENA] & ~ena_ff;
	assign fifo_pop = dma_valid_o & dma_ready_i;

	// ****************************************************************
	// Register updates
	// ****************************************************************
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ena_ff      <= 1'b0;
			sel_ff      <= 1'b0;
			match_en_ff <= 1'b0;
			ie_ff       <= 1'b0;
			act_ff      <= 1'b0;
			done_p_ff   <= 1'b1;
			done_s_ff   <= 1'b1;
			err_ff      <= 1'b0;
			match_ff    <= `SRBC_MATCH_RESET;
		end else if (clr) begin
			ena_ff      <= 1'b0;
			sel_ff      <= 1'b0;
			match_en_ff <= 1'b0;
			ie_ff       <= 1'b0;
			act_ff      <= 1'b0;
			done_p_ff   <= 1'b1;
			done_s_ff   <= 1'b1;
			err_ff      <= 1'b0;
			match_ff    <= `SRBC_MATCH_RESET;
		end else begin
			if (csr_wr_i) begin
				ena_ff      <= csr_wdata_i[`SRBC_BIT_ENA];
				match_en_ff <= csr_wdata_i[`SRBC_BIT_MATCH];
				ie_ff       <= csr_wdata_i[`SRBC_BIT_IE];
			end
			if (ena_rise)
				err_ff <= 1'b0;
			if (match_wr_i)
				match_ff <= match_wdata_i;
			// Count writes clear done; a completing message in the same cycle wins.
			if (cnt_pri_wr_i)
				done_p_ff <= 1'b0;
			if (cnt_sec_wr_i)
				done_s_ff <= 1'b0;
			if (csr_wr_i)
				sel_ff <= csr_wdata_i[`SRBC_BIT_SEL];
			if (run && msg_start_i)
				act_ff <= 1'b1;
			if (csr_wr_i && !csr_wdata_i[`SRBC_BIT_ENA])
				act_ff <= 1'b0;
			if (msg_fin) begin
				sel_ff <= ~sel_ff;
				act_ff <= 1'b0;
				if (sel_ff)
					done_s_ff <= 1'b1;
				else
					done_p_ff <= 1'b1;
				if (msg_error_i) begin
					err_ff <= 1'b1;
					ena_ff <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Character match and outputs
	// ****************************************************************
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			match_hit_ff    <= 1'b0;
			irq_o           <= 1'b0;
			rx_char_ready_o <= 1'b0;
			rx_enabled_o    <= 1'b0;
			buf_sel_o       <= 1'b0;
			csr_rdata_o     <= 16'h0000;
		end else begin
			match_hit_ff    <= take & match_en_ff & general_byte_protocol_mode_i &
				(rx_char_i == match_ff[7:0]);
			irq_o           <= ie_ff & (done_p_ff | done_s_ff | err_ff |
				match_hit_ff);
			// Ready drops for a cycle after any event that may stop the receiver or fill the FIFO.
			rx_char_ready_o <= run & fifo_in_ready & ~take & ~csr_wr_i & ~msg_fin & ~clr;
			rx_enabled_o    <= run;
			buf_sel_o       <= sel_ff;
			csr_rdata_o     <= nxt_rdata;
		end
	end

	always @* begin
		nxt_rdata = 16'h0000;
		nxt_rdata[`SRBC_BIT_ENA]     = ena_ff;
		nxt_rdata[`SRBC_BIT_SEL]     = sel_ff;
		nxt_rdata[`SRBC_BIT_MATCH]   = match_en_ff;
		nxt_rdata[`SRBC_BIT_UNUSED4] = 1'b0;
		nxt_rdata[`SRBC_BIT_IE]      = ie_ff;
		nxt_rdata[`SRBC_BIT_ACT]     = act_ff;
		nxt_rdata[`SRBC_BIT_DONE_S]  = done_s_ff;
		nxt_rdata[`SRBC_BIT_ERR]     = err_ff;
		nxt_rdata[`SRBC_BIT_DONE_P]  = done_p_ff;
	end

	// ****************************************************************
	// Character buffer toward memory
	// ****************************************************************
	srbc_fifo #(
		.WIDTH(`SRBC_FIFO_WIDTH),
		.DEPTH(`SRBC_FIFO_DEPTH),
		.AW   (`SRBC_FIFO_AW)
	) u_fifo (
		.clk_sys_i  (clk_sys_i),
		.rst_b_i    (rst_b_i),
		.clr_i      (clr),
		.in_data_i  (rx_char_i),
		.in_valid_i (take),
		.in_ready_o (fifo_in_ready),
		.out_data_o (fifo_out_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(~dma_valid_o | dma_ready_i)
	);

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dma_valid_o <= 1'b0;
			dma_data_o  <= 8'h00;
		end else if (clr) begin
			dma_valid_o <= 1'b0;
		end else if (!dma_valid_o || dma_ready_i) begin
			dma_valid_o <= fifo_out_valid;
			dma_data_o  <= fifo_out_data;
		end
	end
	wire unused_pop = fifo_pop;
endmodule
`default_nettype wire

// ---- verification/srbc_asserts.sv ----
// Port checker for srbc_top.
// Assumes a bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module srbc_asserts (
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic        bus_init_i,
	input wire logic        csr_wr_i,
	input wire logic [15:0] csr_wdata_i,
	input wire logic [15:0] csr_rdata_o,
	input wire logic        match_wr_i,
	input wire logic [7:0]  match_wdata_i,
	input wire logic        cnt_pri_wr_i,
	input wire logic        general_byte_protocol_mode_i,
	input wire logic [7:0]  rx_char_i,
	input wire logic        rx_char_valid_i,
	input wire logic        rx_char_ready_o,
	input wire logic        msg_end_i,
	input wire logic        rx_enabled_o,
	input wire logic        buf_sel_o,
	input wire logic        irq_o
);
	logic [7:0] m_ff;
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			m_ff <= 8'h00;
		else if (match_wr_i)
			m_ff <= match_wdata_i;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	property p_zero4; csr_rdata_o[4] == 1'b0; endproperty
	a_zero4: assert property (p_zero4) else $error("bit 4 set");
	property p_init; bus_init_i |=> ##1 (csr_rdata_o & 16'h002C) == 16'h0000; endproperty
	a_init: assert property (p_init) else $error("init kept bits");
	property p_sel; csr_rdata_o[2] == buf_sel_o; endproperty
	a_sel: assert property (p_sel) else $error("select image");
	property p_flip; msg_end_i && rx_enabled_o && !bus_init_i |=> ##1 buf_sel_o != $past(buf_sel_o);
	endproperty
	a_flip: assert property (p_flip) else $error("no toggle");
	property p_clr; cnt_pri_wr_i && !msg_end_i |=> ##1 !csr_rdata_o[15]; endproperty
	a_clr: assert property (p_clr) else $error("done kept");
	property p_ena; csr_wr_i && !csr_wdata_i[0] |-> ##[1:2] !rx_enabled_o; endproperty
	a_ena: assert property (p_ena) else $error("runs disabled");
	property p_hit; rx_char_valid_i && rx_char_ready_o && general_byte_protocol_mode_i && csr_rdata_o[3]
		&& csr_rdata_o[5] && rx_char_i == m_ff |-> ##[1:2] irq_o; endproperty
	a_hit: assert property (p_hit) else $error("no match irq");
	property p_mask; (!csr_rdata_o[5]) [*3] |-> !irq_o; endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
	c_irq: cover property ($rose(irq_o));
	c_flip: cover property (msg_end_i && rx_enabled_o);
	c_init: cover property (bus_init_i);
endmodule
`default_nettype wire

// ---- verification/srbc_mem_model.sv ----
// Memory side: takes a DMA byte every other cycle unless stalled.
// Assumes the design's clock.
`timescale 1ns/1ps
`default_nettype none
module srbc_mem_model (
	input  wire logic clk_sys_i,
	input  wire logic stall_i,
	output wire logic dma_ready_o
);
	logic slow_ff = 1'b0;
	always @(posedge clk_sys_i) slow_ff <= ~slow_ff;
	assign dma_ready_o = slow_ff & ~stall_i;
endmodule
`default_nettype wire

// ---- verification/srbc_top_tb_top.sv ----
// Bench for srbc_top: register port, messages, DMA drain.
// Assumes the checker and memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module srbc_top_tb_top;
	logic clk_sys_i, rst_b_i, bus_init_i, csr_wr_i, match_wr_i, cnt_pri_wr_i, cnt_sec_wr_i;
	logic general_byte_protocol_mode_i, msg_start_i, rx_char_valid_i, msg_end_i, msg_error_i, stall;
	logic sel, dp, ds, ie;
	logic [15:0] csr_wdata_i;
	logic [7:0] match_wdata_i, rx_char_i, r, m;
	wire [15:0] csr_rdata_o;
	wire [7:0] dma_data_o;
	wire rx_char_ready_o, dma_valid_o, dma_ready_i, rx_enabled_o, buf_sel_o, irq_o;
	integer err_count, total_checks, n_irq, k, i;
	logic [7:0] exp_q[$];
	srbc_top u_dut (.*);
	srbc_mem_model u_mem (.clk_sys_i, .stall_i(stall), .dma_ready_o(dma_ready_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	function [7:0] lf(input [7:0] s);
		lf = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task tick(input integer n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task final_report;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input [15:0] e, input [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task chk_st(input logic run);
		chk("csr", {dp, 7'h00, ds, 1'b0, ie, 2'b01, sel, 2'b01}, csr_rdata_o);
		chk("run", {15'h0000, run}, {15'h0000, rx_enabled_o});
		chk("sel", {15'h0000, sel}, {15'h0000, buf_sel_o});
	endtask
	task wr(input [15:0] d);
		csr_wr_i <= 1'b1;
		csr_wdata_i <= d;
		tick(1);
		csr_wr_i <= 1'b0;
	endtask
	task send(input [7:0] c);
		integer n;
		rx_char_i <= c;
		rx_char_valid_i <= 1'b1;
		n = 0;
		tick(1);
		while (rx_char_ready_o !== 1'b1) begin
			if (n == 40 && stall) begin
				chk("fill", 16'h0001, {15'h0000, exp_q.size() >= 16});
				stall <= 1'b0;
			end
			if (++n > 300) begin
				err_count++;
				final_report;
			end
			tick(1);
		end
		exp_q.push_back(c);
	endtask
	always @(posedge clk_sys_i) begin
		if ($rose(irq_o))
			n_irq++;
		if (dma_valid_o === 1'b1 && dma_ready_i === 1'b1)
			chk("dma", {8'h00, exp_q.pop_front()}, {8'h00, dma_data_o});
	end
	initial begin
		{bus_init_i, csr_wr_i, match_wr_i, cnt_pri_wr_i, cnt_sec_wr_i, msg_start_i} = 6'h00;
		{rx_char_valid_i, msg_end_i, msg_error_i, general_byte_protocol_mode_i, stall} = 5'h00;
		{csr_wdata_i, match_wdata_i, rx_char_i} = 32'h0000_0000;
		err_count = 0;
		total_checks = 0;
		r = 8'h28;
		rst_b_i = 1'b0;
		tick(6);
		rst_b_i <= 1'b1;
		tick(3);
		chk("csr", 16'h8080, csr_rdata_o);
		r = lf(r);
		m = r;
		match_wdata_i <= m;
		match_wr_i <= 1'b1;
		tick(1);
		match_wr_i <= 1'b0;
		{sel, dp, ds} = 3'b011;
		for (i = 0; i < 3; i++) begin
			ie = (i != 1);
			wr({10'h000, ie, 2'b11, sel, 2'b01});
			tick(3);
			chk_st(!(sel ? ds : dp));
			if (i != 1) begin
				{cnt_pri_wr_i, cnt_sec_wr_i} <= 2'b11;
				tick(1);
				{cnt_pri_wr_i, cnt_sec_wr_i} <= 2'b00;
				{dp, ds} = 2'b00;
				tick(3);
				chk_st(1'b1);
			end
			general_byte_protocol_mode_i <= (i != 2);
			stall <= (i == 0);
			msg_start_i <= 1'b1;
			tick(1);
			msg_start_i <= 1'b0;
			n_irq = 0;
			for (k = 0; k < 20; k++) begin
				r = lf(r);
				send((k == 4 || k == 11) ? m : ((r == m) ? ~m : r));
			end
			rx_char_valid_i <= 1'b0;
			for (k = 0; k < 300 && exp_q.size() > 0; k++)
				tick(1);
			if (exp_q.size() > 0) begin
				err_count++;
				final_report;
			end
			tick(4);
			chk("active", 16'h0001, {15'h0000, csr_rdata_o[6]});
			chk("irq_count", (i == 0) ? 16'h0002 : 16'h0000, n_irq[15:0]);
			{msg_end_i, msg_error_i} <= {i != 2, i == 2};
			tick(1);
			{msg_end_i, msg_error_i} <= 2'b00;
			if (sel)
				ds = 1'b1;
			else
				dp = 1'b1;
			sel = !sel;
		end
		tick(3);
		chk("err", {3'b100, sel}, {csr_rdata_o[14], csr_rdata_o[6], csr_rdata_o[0], buf_sel_o});
		wr(16'h0000);
		bus_init_i <= 1'b1;
		tick(1);
		bus_init_i <= 1'b0;
		tick(3);
		chk("csr", 16'h8080, csr_rdata_o);
		final_report;
	end
endmodule
bind srbc_top srbc_asserts u_chk (.*);
`default_nettype wire
